/* File: shared/mce_pkg.sv */
// constants, register map and types of the memory-range checksum engine
package mce_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int PADDR_W = 8;                 // apb byte address width
	localparam int DATA_W  = 32;                // apb and memory data width

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [PADDR_W-1:0] OFF_CTRL = 8'h00;   // control_reg, write-only
	localparam logic [PADDR_W-1:0] OFF_STAT = 8'h04;   // status_reg, read-only
	localparam logic [PADDR_W-1:0] OFF_SCR  = 8'h08;   // status_flag_clear, write-only
	localparam logic [PADDR_W-1:0] OFF_ADDR = 8'h0C;   // range start address
	localparam logic [PADDR_W-1:0] OFF_LEN  = 8'h10;   // range length in bytes
	localparam logic [PADDR_W-1:0] OFF_DATA = 8'h14;   // seed in, checksum out

	// ------------------------------------------------------------
	// control_reg fields
	// ------------------------------------------------------------
	localparam int CTRL_EN  = 0;                // module_enable
	localparam int CTRL_DIS = 1;                // module_disable
	localparam int CTRL_CRC = 2;                // checksum_start

	// ------------------------------------------------------------
	// status flags, same positions in status_reg and status_flag_clear
	// ------------------------------------------------------------
	localparam int FLAG_DONE = 0;               // run finished
	localparam int FLAG_HOLD = 1;               // core_hold_flag
	localparam int FLAG_BUS_ERROR_FLAG = 2;               // bus_error_flag
	localparam int FLAG_FAIL = 3;               // functional error
	localparam int FLAG_LOCK = 4;               // lock_flag
	localparam int NFLAG     = 5;               // number of sticky flags
	localparam int STAT_BUSY = 5;               // run in progress
	localparam int STAT_ENA  = 6;               // module enabled

	// ------------------------------------------------------------
	// checksum and range constants
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] CRC_POLY   = 32'hEDB88320;  // reflected generator
	localparam logic [DATA_W-1:0] CRC_SEED   = 32'hFFFFFFFF;  // usual seed
	localparam logic [DATA_W-1:0] FLASH_BASE = 32'h00000000;  // forced start in protected state
	localparam logic [DATA_W-1:0] FLASH_SIZE = 32'h00010000;  // forced length in protected state
	localparam logic [DATA_W-1:0] WORD_BYTES = 32'h00000004;  // bytes per fetch
	localparam logic [DATA_W-1:0] ALIGN_MASK = 32'h00000003;  // low bits that must be zero

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] ADDR_RST = 32'h00000000;
	localparam logic [DATA_W-1:0] LEN_RST  = 32'h00000000;
	localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;
	localparam logic              ENA_RST  = 1'b1;

	// ------------------------------------------------------------
	// engine states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_FETCH = 2'b10
	} mce_state_t;

endpackage

/* File: design/mce_sticky_flag.sv */
// one sticky status flag: hardware set wins over software clear
`timescale 1ns/1ps
module mce_sticky_flag (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// set and clear strobes
	input  wire logic setFlag,
	input  wire logic clrFlag,
	// flag level
	output logic      flag
);

	// ------------------------------------------------------------
	// flag register
	// ------------------------------------------------------------
	logic flag_ff;   // stored flag

	// set has priority so an event in the clearing cycle survives
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			flag_ff <= 1'b0;
		end else if (setFlag) begin
			flag_ff <= 1'b1;
		end else if (clrFlag) begin
			flag_ff <= 1'b0;
		end
	end

	assign flag = flag_ff;

endmodule

/* File: design/mce_crc_fold.sv */
// folds one 32-bit word into the running reflected crc32, low byte first
`timescale 1ns/1ps
module mce_crc_fold
	import mce_pkg::*;
(
	// running value and new word
	input  wire logic [mce_pkg::DATA_W-1:0] crcIn,
	input  wire logic [mce_pkg::DATA_W-1:0] dataIn,
	// updated value
	output logic      [mce_pkg::DATA_W-1:0] crcOut
);

	// ------------------------------------------------------------
	// bitwise shift-right division, bit 0 of byte 0 first
	// ------------------------------------------------------------
	always_comb begin
		logic [DATA_W-1:0] c;   // working remainder
		c = crcIn;
		for (int i = 0; i < DATA_W; i++) begin
			if (c[0] ^ dataIn[i]) begin
				c = (c >> 1) ^ CRC_POLY;
			end else begin
				c = c >> 1;
			end
		end
		crcOut = c;
	end

endmodule

/* File: design/mce_crc_engine.sv */
// apb-controlled engine that checksums a memory range with crc32
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module mce_crc_engine
	import mce_pkg::*;
(
	// clock and reset
	input  wire logic                        mclk,
	input  wire logic                        rst,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [mce_pkg::PADDR_W-1:0] paddr,
	input  wire logic [mce_pkg::DATA_W-1:0]  pwdata,
	output logic      [mce_pkg::DATA_W-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	// memory read port
	output logic                             memReq,
	output logic      [mce_pkg::DATA_W-1:0]  memAddr,
	input  wire logic                        memAck,
	input  wire logic [mce_pkg::DATA_W-1:0]  memRdata,
	input  wire logic                        memErr,
	// chip state
	input  wire logic                        protectedState,
	input  wire logic                        coreHoldSet,
	input  wire logic                        lockSet,
	// state outputs
	output logic                             coreHold,
	output logic                             busy
);
	import mce_pkg::*;

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	mce_state_t        state_ff;        // engine state
	mce_state_t        nxt_state;       // next engine state
	logic [DATA_W-1:0] addr_ff;         // fetch address
	logic [DATA_W-1:0] len_ff;          // bytes still to fetch
	logic [DATA_W-1:0] data_ff;         // seed and checksum
	logic              enabled_ff;      // module accepts operations
	logic [DATA_W-1:0] prdata_ff;       // read data latched in setup
	logic              pslverr_ff;      // unmapped address seen in setup
	logic [DATA_W-1:0] crcNext;         // checksum with fetched word folded
	logic [NFLAG-1:0]  flags;           // sticky status flags
	logic [NFLAG-1:0]  flagSet;         // hardware set strobes
	logic [NFLAG-1:0]  flagClr;         // software clear strobes
	logic              setupPhase;      // apb setup cycle
	logic              wrAccess;        // apb write completes now
	logic              ctrlWr;          // write to control_reg
	logic              startReq;        // start bit written
	logic              disableReq;      // disable bit written
	logic              enableReq;       // enable bit written
	logic              startOk;         // start accepted
	logic [DATA_W-1:0] startAddr;       // address taken at start
	logic [DATA_W-1:0] startLen;        // length taken at start
	logic              misaligned;      // start range not word aligned
	logic              runGo;           // start that launches fetching
	logic              wordDone;        // fetch returned good data
	logic              lastWord;        // fetch returned the final word
	logic              busErr;          // fetch returned an error
	logic              regWrOk;         // range registers writable
	logic              mapped;          // setup address decodes

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero wait state slave: every access phase completes at once
	assign pready     = 1'b1;
	assign prdata     = prdata_ff;
	assign pslverr    = pslverr_ff;
	assign setupPhase = psel & ~penable;
	assign wrAccess   = psel & penable & pwrite;
	assign ctrlWr     = wrAccess & (paddr == OFF_CTRL);
	assign startReq   = ctrlWr & pwdata[CTRL_CRC];
	assign disableReq = ctrlWr & pwdata[CTRL_DIS];
	assign enableReq  = ctrlWr & pwdata[CTRL_EN];
	// range registers are frozen while a run is going
	assign regWrOk    = wrAccess & (state_ff == ST_IDLE);

	// address decode for the error answer
	always_comb begin
		case (paddr)
			OFF_CTRL, OFF_STAT, OFF_SCR,
			OFF_ADDR, OFF_LEN, OFF_DATA: begin
				mapped = 1'b1;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// start qualification
	// ------------------------------------------------------------
	// a start counts only when enabled, idle and not disabled now
	assign startOk = startReq & enabled_ff & ~disableReq
		& (state_ff == ST_IDLE);

	// protected state replaces the requested range by whole flash
	assign startAddr = protectedState ? FLASH_BASE : addr_ff;
	assign startLen  = protectedState ? FLASH_SIZE : len_ff;

	// an unaligned range is refused and reported as functional error
	assign misaligned = ((startAddr | startLen) & ALIGN_MASK) != '0;
	assign runGo      = startOk & ~misaligned & (startLen != '0);

	// ------------------------------------------------------------
	// fetch results
	// ------------------------------------------------------------
	assign busErr   = (state_ff == ST_FETCH) & memAck & memErr;
	assign wordDone = (state_ff == ST_FETCH) & memAck & ~memErr;
	assign lastWord = wordDone & (len_ff == WORD_BYTES);

	// fold the returned word into the running checksum
	mce_crc_fold u_fold (
		.crcIn  (data_ff),
		.dataIn (memRdata),
		.crcOut (crcNext)
	);

	// ------------------------------------------------------------
	// engine state machine
	// ------------------------------------------------------------
	// next state: disable wins, then fetch completion, then start
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (runGo) begin
					nxt_state = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (disableReq) begin
					nxt_state = ST_IDLE;
				end else if (busErr | lastWord) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// memory port follows the state directly
	assign memReq  = (state_ff == ST_FETCH);
	assign memAddr = addr_ff;
	assign busy    = (state_ff == ST_FETCH);

	// ------------------------------------------------------------
	// enable state
	// ------------------------------------------------------------
	// disable drops acceptance until software enables again
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			enabled_ff <= ENA_RST;
		end else if (disableReq) begin
			enabled_ff <= 1'b0;
		end else if (enableReq) begin
			enabled_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// address register
	// ------------------------------------------------------------
	// loaded by software, forced at a protected start, stepped per word
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			addr_ff <= ADDR_RST;
		end else if (runGo) begin
			addr_ff <= startAddr;
		end else if (wordDone) begin
			addr_ff <= addr_ff + WORD_BYTES;
		end else if (regWrOk & (paddr == OFF_ADDR)) begin
			addr_ff <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// length register
	// ------------------------------------------------------------
	// counts down the bytes still to fetch
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			len_ff <= LEN_RST;
		end else if (runGo) begin
			len_ff <= startLen;
		end else if (wordDone) begin
			len_ff <= len_ff - WORD_BYTES;
		end else if (regWrOk & (paddr == OFF_LEN)) begin
			len_ff <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// data register
	// ------------------------------------------------------------
	// seed in, raw checksum out; never inverted by the engine
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_ff <= DATA_RST;
		end else if (runGo & protectedState) begin
			data_ff <= CRC_SEED;
		end else if (wordDone) begin
			data_ff <= crcNext;
		end else if (regWrOk & (paddr == OFF_DATA)) begin
			data_ff <= pwdata;
		end
	end

	// ------------------------------------------------------------
	// status flags
	// ------------------------------------------------------------
	// hardware set strobes
	always_comb begin
		flagSet            = '0;
		flagSet[FLAG_DONE] = busErr | lastWord
			| (startOk & (misaligned | (startLen == '0)));
		flagSet[FLAG_HOLD] = coreHoldSet;
		flagSet[FLAG_BUS_ERROR_FLAG] = busErr;
		flagSet[FLAG_FAIL] = startOk & misaligned;
		flagSet[FLAG_LOCK] = lockSet;
	end

	// software clear strobes, plus start and disable side effects
	always_comb begin
		flagClr = '0;
		if (wrAccess & (paddr == OFF_SCR)) begin
			flagClr = pwdata[NFLAG-1:0];
		end
		if (protectedState) begin
			flagClr[FLAG_HOLD] = 1'b0;
		end
		if (startOk | disableReq) begin
			flagClr[FLAG_DONE] = 1'b1;
			flagClr[FLAG_BUS_ERROR_FLAG] = 1'b1;
			flagClr[FLAG_FAIL] = 1'b1;
		end
	end

	// one sticky flag per flag bit, NFLAG in all; busy and enable bits have none
	genvar g;
	generate
		for (g = 0; g < NFLAG; g++) begin : g_flag
			mce_sticky_flag u_flag (
				.mclk    (mclk),
				.rst     (rst),
				.setFlag (flagSet[g]),
				.clrFlag (flagClr[g]),
				.flag    (flags[g])
			);
		end
	endgenerate

	assign coreHold = flags[FLAG_HOLD];

	// ------------------------------------------------------------
	// apb read data and error answer
	// ------------------------------------------------------------
	// captured in the setup cycle so the access phase sees flops
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			prdata_ff  <= '0;
			pslverr_ff <= 1'b0;
		end else if (setupPhase) begin
			pslverr_ff <= ~mapped;
			prdata_ff  <= '0;
			if (~pwrite) begin
				case (paddr)
					OFF_STAT: begin
						prdata_ff[NFLAG-1:0] <= flags;
						prdata_ff[STAT_BUSY] <= busy;
						prdata_ff[STAT_ENA]  <= enabled_ff;
					end
					OFF_ADDR: begin
						prdata_ff <= addr_ff;
					end
					OFF_LEN: begin
						prdata_ff <= len_ff;
					end
					OFF_DATA: begin
						prdata_ff <= data_ff;
					end
					default: begin
						prdata_ff <= '0;
					end
				endcase
			end
		end
	end

endmodule

/* File: verif/mce_crc_engine_props.sv */
// port-level concurrent checks of the checksum engine
`timescale 1ns/1ps
module mce_crc_engine_props
	import mce_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// memory read port
	input wire logic        memReq,
	input wire logic [31:0] memAddr,
	input wire logic        memAck,
	input wire logic [31:0] memRdata,
	input wire logic        memErr,
	// chip state
	input wire logic        protectedState,
	input wire logic        coreHoldSet,
	input wire logic        lockSet,
	input wire logic        coreHold,
	input wire logic        busy
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic wrCtrl;  // write to control_reg takes effect
	logic wrClr;   // write to status_flag_clear takes effect
	logic startWr; // start written without disable
	logic rdStat;  // status_reg read in its access phase
	assign wrCtrl  = psel && penable && pwrite && paddr == OFF_CTRL;
	assign wrClr   = psel && penable && pwrite && paddr == OFF_SCR;
	assign startWr = wrCtrl && pwdata[CTRL_CRC] && !pwdata[CTRL_DIS];
	assign rdStat  = psel && penable && !pwrite && paddr == OFF_STAT;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	a_addr_step: assert property (memReq && memAck && !memErr |=> !memReq || memAddr == $past(memAddr) + WORD_BYTES)
		else $error("fetch address did not step one word");
	a_addr_hold: assert property (memReq && !memAck |=> !memReq || $stable(memAddr))
		else $error("fetch address moved before answer");
	a_req_busy: assert property (memReq |-> busy)
		else $error("fetch outside a run");
	a_abort_stop: assert property (wrCtrl && pwdata[CTRL_DIS] |=> (!busy && !memReq) [*2])
		else $error("run survived disable");
	a_start_ignored: assert property (busy && startWr && !memAck |=> busy && $stable(memAddr))
		else $error("start during run disturbed it");
	a_err_ends: assert property (memReq && memAck && memErr |=> !busy && !memReq)
		else $error("bus error did not end run");
	a_hold_kept: assert property (wrClr && pwdata[FLAG_HOLD] && protectedState && coreHold |=> coreHold)
		else $error("core hold cleared while protected");
	a_hold_clear: assert property (wrClr && pwdata[FLAG_HOLD] && !protectedState && !coreHoldSet |=> !coreHold)
		else $error("core hold not cleared");
	a_zero_noeffect: assert property (wrClr && !pwdata[FLAG_HOLD] && coreHold |=> coreHold)
		else $error("zero bit cleared core hold");
	a_done_clear: assert property (rdStat && prdata[STAT_BUSY] |-> !prdata[FLAG_DONE])
		else $error("done seen during run");
	a_prot_base: assert property (startWr && protectedState && !busy |=> !busy || memAddr == FLASH_BASE)
		else $error("protected run not at flash base");
	// main scenarios reached
	c_run: cover property (wrCtrl && pwdata[CTRL_CRC] && !busy);
	c_bus_error_flag: cover property (memAck && memErr);
	c_abort: cover property (wrCtrl && pwdata[CTRL_DIS] && busy);
endmodule

bind mce_crc_engine mce_crc_engine_props u_props (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.memReq(memReq), .memAddr(memAddr), .memAck(memAck), .memRdata(memRdata), .memErr(memErr),
	.protectedState(protectedState), .coreHoldSet(coreHoldSet), .lockSet(lockSet), .coreHold(coreHold),
	.busy(busy));

/* File: verif/mce_mem_model.sv */
// behavioural system memory answering the engine's word fetches
`timescale 1ns/1ps
module mce_mem_model (
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// fetch port
	input wire logic        memReq,
	input wire logic [31:0] memAddr,
	output logic            memAck,
	output logic [31:0]     memRdata,
	output logic            memErr,
	// bench controls
	input wire logic [7:0]  latency,
	input wire logic [31:0] errAddr,
	output logic [15:0]     ackCnt
);
	logic [7:0] waitCnt_ff;  // cycles waited on current fetch
	// memory content pattern, derived from the address
	function automatic logic [31:0] word_at(input logic [31:0] a);
		return {a[15:0] ^ 16'h5A3C, ~a[15:0]};
	endfunction
	// one answer per request after latency cycles
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			memAck     <= 1'b0;
			memErr     <= 1'b0;
			memRdata   <= 32'h0;
			waitCnt_ff <= 8'h0;
			ackCnt     <= 16'h0;
		end else begin
			memAck   <= 1'b0;
			memErr   <= 1'b0;
			memRdata <= ~memRdata;  // released data toggles each cycle, so it differs from the last word one cycle after the answer
			if (memReq && !memAck) begin
				if (waitCnt_ff >= latency) begin
					memAck     <= 1'b1;
					memRdata   <= word_at(memAddr);
					memErr     <= memAddr == errAddr;
					waitCnt_ff <= 8'h0;
					ackCnt     <= ackCnt + 16'h1;
				end else begin
					waitCnt_ff <= waitCnt_ff + 8'h1;
				end
			end else if (!memReq) begin
				waitCnt_ff <= 8'h0;  // an aborted fetch leaves no wait count behind
			end
		end
	end
endmodule

/* File: verif/memory_crc32_engine_tb.sv */
// self-checking bench of the checksum engine over apb
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin numChecks++; if ((got) !== (exp)) begin errorCnt++; \
	$display("mismatch %s expected %h seen %h", nm, exp, got); end end
module memory_crc32_engine_tb;
	import mce_pkg::*;
	logic mclk, rst, psel, penable, pwrite, pready, pslverr, memReq, memAck, memErr;
	logic protectedState, coreHoldSet, lockSet, coreHold, busy, lastErr;
	logic [7:0]  paddr, latency;
	logic [31:0] pwdata, prdata, memAddr, memRdata, errAddr, rdData;
	logic [15:0] ackCnt, ackBase;
	int          errorCnt, numChecks;
	mce_crc_engine u_mce_crc_engine (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .memReq(memReq),
		.memAddr(memAddr), .memAck(memAck), .memRdata(memRdata), .memErr(memErr),
		.protectedState(protectedState), .coreHoldSet(coreHoldSet), .lockSet(lockSet),
		.coreHold(coreHold), .busy(busy));
	mce_mem_model u_mce_mem_model (.mclk(mclk), .rst(rst), .memReq(memReq), .memAddr(memAddr),
		.memAck(memAck), .memRdata(memRdata), .memErr(memErr), .latency(latency), .errAddr(errAddr),
		.ackCnt(ackCnt));
	// ----------------------------------------
	// clock, verdict and watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	task automatic reportAndStop();
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (50000) @(posedge mclk);
		errorCnt++;
		reportAndStop();
	end
	// ----------------------------------------
	// apb transfer, run helpers, expected checksum
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rdData = prdata;
		lastErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chkReg(input logic [7:0] a, input logic [31:0] exp, input string nm);
		xfer(1'b0, a, 32'h0);
		`CHK(nm, exp, rdData)
	endtask
	task automatic startRun(input logic [31:0] a, input logic [31:0] len, input logic [31:0] seed);
		xfer(1'b1, OFF_ADDR, a);
		xfer(1'b1, OFF_LEN, len);
		xfer(1'b1, OFF_DATA, seed);
		xfer(1'b1, OFF_CTRL, 32'h4);
	endtask
	task automatic runRange(input logic [31:0] a, input logic [31:0] len, input logic [31:0] seed);
		startRun(a, len, seed);
		repeat (2) @(posedge mclk);
		while (busy !== 1'b0) @(posedge mclk);
	endtask
	function automatic logic [31:0] crcOf(input logic [31:0] seed, input logic [31:0] base, input int n);
		logic [31:0] c;
		c = seed;
		for (int w = 0; w < n; w++) begin
			c ^= u_mce_mem_model.word_at(base + 32'(4 * w));
			for (int b = 0; b < 32; b++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
		end
		return c;
	endfunction
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, protectedState, coreHoldSet, lockSet} = 6'h0;
		paddr = 8'h0; pwdata = 32'h0; latency = 8'h0; errAddr = 32'hFFFFFFFC;
		errorCnt = 0; numChecks = 0; rst = 1'b1;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		chkReg(OFF_STAT, 32'h40, "status after reset");
		`CHK("mapped error", 1'b0, lastErr)
		xfer(1'b0, 8'h18, 32'h0);
		`CHK("unmapped error", 1'b1, lastErr)
		runRange(32'h100, 32'h10, CRC_SEED);
		chkReg(OFF_DATA, crcOf(CRC_SEED, 32'h100, 4), "checksum");
		chkReg(OFF_STAT, 32'h41, "status done");
		xfer(1'b1, OFF_SCR, 32'h0);
		chkReg(OFF_STAT, 32'h41, "zero clear");
		xfer(1'b1, OFF_SCR, 32'h1);
		chkReg(OFF_STAT, 32'h40, "done cleared");
		// chained slow run with interfering writes
		latency <= 8'd3;
		startRun(32'h110, 32'h20, crcOf(CRC_SEED, 32'h100, 4));
		chkReg(OFF_STAT, 32'h60, "status while busy");
		xfer(1'b1, OFF_DATA, 32'h0);
		xfer(1'b1, OFF_CTRL, 32'h4);
		while (busy !== 1'b0) @(posedge mclk);
		chkReg(OFF_DATA, crcOf(CRC_SEED, 32'h100, 12), "chained checksum");
		// bus error on third word
		latency <= 8'd0;
		errAddr <= 32'h208;
		runRange(32'h200, 32'h10, CRC_SEED);
		chkReg(OFF_STAT, 32'h45, "bus error status");
		chkReg(OFF_DATA, crcOf(CRC_SEED, 32'h200, 2), "partial checksum");
		runRange(32'h102, 32'h8, CRC_SEED);
		chkReg(OFF_STAT, 32'h49, "misaligned status");
		// lock and core hold flags
		lockSet <= 1'b1;
		coreHoldSet <= 1'b1;
		@(posedge mclk);
		lockSet <= 1'b0;
		coreHoldSet <= 1'b0;
		xfer(1'b1, OFF_SCR, 32'h1);
		chkReg(OFF_STAT, 32'h5A, "done only cleared");
		protectedState <= 1'b1;
		xfer(1'b1, OFF_SCR, 32'h1A);
		chkReg(OFF_STAT, 32'h42, "hold kept");
		protectedState <= 1'b0;
		xfer(1'b1, OFF_SCR, 32'h2);
		@(posedge mclk);
		`CHK("core hold", 1'b0, coreHold)
		// abort, refused start, re-enable
		latency <= 8'd4;
		startRun(32'h300, 32'h40, CRC_SEED);
		xfer(1'b1, OFF_CTRL, 32'h2);
		@(posedge mclk);
		`CHK("busy after disable", 1'b0, busy)
		chkReg(OFF_ADDR, 32'h300, "address after abort");
		xfer(1'b0, OFF_STAT, 32'h0);
		`CHK("state after disable", 2'b00, rdData[6:5])
		startRun(32'h100, 32'h4, CRC_SEED);
		@(posedge mclk);
		`CHK("start while disabled", 1'b0, busy)
		xfer(1'b1, OFF_CTRL, 32'h1);
		runRange(32'h100, 32'h4, CRC_SEED);
		chkReg(OFF_DATA, crcOf(CRC_SEED, 32'h100, 1), "after enable");
		// protected start forces whole flash and seed
		protectedState <= 1'b1;
		latency <= 8'd5;
		ackBase = ackCnt;
		startRun(32'h500, 32'h4, 32'h1234);
		while (ackCnt !== ackBase + 16'd3) @(posedge mclk);
		xfer(1'b1, OFF_CTRL, 32'h2);
		protectedState <= 1'b0;
		chkReg(OFF_DATA, crcOf(CRC_SEED, FLASH_BASE, 3), "protected checksum");
		reportAndStop();
	end
endmodule
